// file: dram_burst_page_edo_timing.sv
// strobe, address and data-bus sequencer for page-mode and edo dram
//
// Behaviour
// [R1] RAS falls half clock after row address
// [R2] second edge: drop start, column, write data
// [R3] 16-bit port: both CAS at column
// [R4] acknowledge one cycle before beat completes
// [R5] between beats: next column with next data
// [R6] burst page mode closes page after burst
// [R7] release data bus after last write beat
// [R8] two clocks after RAS close before start; after a page miss the code starts one clock after close
// [R9] nonburst in burst page acts as normal
// [R10] word read: row, read, size, start
// [R11] read captured, strobes dropped same edge
// [R12] timing register bit selects edo CAS
// [R13] edo drops CAS half clock earlier
// [R14] edo gives full clock CAS precharge
// [R15] edo: CAS drops at ack falling edge
// [R16] 8-bit port: lowest CAS, top byte
// [R17] fast page mode keeps page open
// [R18] page miss: close RAS, precharge, reopen
// [R19] byte read: byte size, read, start
// [R20] system avoids edo contention on nondram
// [R21] operand wider than port becomes burst
// [R22] burst: three clocks then two each
// [R23] write indicator low write, high read
`timescale 1ns/1ps
`default_nettype none

module dram_burst_page_edo_timing (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [27:0] reqAddr,
    input  wire logic [1:0]  reqSize,
    input  wire logic [31:0] reqWdata,
    output logic             reqReady,
    output logic             beatAck,
    output logic             reqDone,
    output logic      [31:0] reqRdata,
    output logic      [18:0] dramAddr,
    output logic             rasN,
    output logic      [3:0]  casN,
    output logic             transferStartN,
    output logic             dramWriteIndicatorN,
    output logic      [1:0]  transferSizeCode,
    input  wire logic [31:0] dataIn,
    output logic      [31:0] dataOut,
    output logic      [3:0]  dataOe
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] portBytes(input logic [1:0] p);
        if (p == dram_seq_pkg::PORT_8) begin
            return 3'h1;
        end else if (p == dram_seq_pkg::PORT_16) begin
            return 3'h2;
        end
        return 3'h4;
    endfunction

    function automatic logic [2:0] opBytes(input logic [1:0] s);
        if (s == dram_seq_pkg::SIZE_BYTE) begin
            return 3'h1;
        end else if (s == dram_seq_pkg::SIZE_WORD) begin
            return 3'h2;
        end
        return 3'h4;
    endfunction

    // beats minus one; nonzero means a burst
    function automatic logic [1:0] extraBeats(input logic [1:0] s,
                                              input logic [1:0] p);
        logic [2:0] q;
        q = 3'h0;
        if (opBytes(s) > portBytes(p)) begin
            q = 3'(opBytes(s) / portBytes(p)) - 3'h1;
        end
        return q[1:0];
    endfunction

    function automatic logic [3:0] dataLanes(input logic [1:0] p);
        if (p == dram_seq_pkg::PORT_8) begin
            return 4'h8;
        end else if (p == dram_seq_pkg::PORT_16) begin
            return 4'hC;
        end
        return 4'hF;
    endfunction

    function automatic logic [3:0] casLanes(input logic [1:0] p);
        if (p == dram_seq_pkg::PORT_8) begin
            return 4'h1;
        end else if (p == dram_seq_pkg::PORT_16) begin
            return 4'h3;
        end
        return 4'hF;
    endfunction

    function automatic logic [18:0] colOf(input logic [27:0] a);
        return {10'h000, a[8:0]};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]                timing_r;
    logic [31:0]                timing_nxt;
    logic [31:0]                bankCfg_r;
    logic [31:0]                bankCfg_nxt;
    logic [31:0]                regRdata_r;
    logic [31:0]                regRdata_nxt;
    logic                       edoEnable;
    dram_seq_pkg::state_t       state_r;
    dram_seq_pkg::state_t       state_nxt;
    logic                       pageOpen_r;
    logic                       pageOpen_nxt;
    logic [18:0]                openRow_r;
    logic [18:0]                openRow_nxt;

    assign edoEnable = timing_r[dram_seq_pkg::EDO_BIT]; // R12

    always_comb begin
        timing_nxt   = timing_r;
        bankCfg_nxt  = bankCfg_r;
        regRdata_nxt = 32'h0000_0000;
        if (regWr) begin
            if (regAddr == dram_seq_pkg::TIMING_OFS) begin
                timing_nxt = regWdata;
            end else if (regAddr == dram_seq_pkg::BANKCFG_OFS) begin
                bankCfg_nxt = regWdata;
            end
        end
        if (regRd) begin
            if (regAddr == dram_seq_pkg::TIMING_OFS) begin
                regRdata_nxt = timing_r;
            end else if (regAddr == dram_seq_pkg::BANKCFG_OFS) begin
                regRdata_nxt = bankCfg_r;
            end else if (regAddr == dram_seq_pkg::STATUS_OFS) begin
                regRdata_nxt[dram_seq_pkg::ST_OPEN_BIT] = pageOpen_r;
                regRdata_nxt[dram_seq_pkg::ST_BUSY_BIT] =
                    (state_r != dram_seq_pkg::ST_IDLE);
                regRdata_nxt[dram_seq_pkg::ST_BANK_BIT] = openRow_r[18];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            timing_r   <= dram_seq_pkg::TIMING_RST;
            bankCfg_r  <= dram_seq_pkg::BANKCFG_RST;
            regRdata_r <= 32'h0000_0000;
        end else begin
            timing_r   <= timing_nxt;
            bankCfg_r  <= bankCfg_nxt;
            regRdata_r <= regRdata_nxt;
        end
    end

    assign regRdata = regRdata_r;

    // ------------------------------------------------------------
    // transfer sequencer, rising edge
    // ------------------------------------------------------------
    logic [1:0]  beatsLeft_r;
    logic [1:0]  beatsLeft_nxt;
    logic [27:0] curAddr_r;
    logic [27:0] curAddr_nxt;
    logic [18:0] addrOut_r;
    logic [18:0] addrOut_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        write_r;
    logic        write_nxt;
    logic        dirN_r;
    logic        dirN_nxt;
    logic [1:0]  size_r;
    logic [1:0]  size_nxt;
    logic [1:0]  port_r;
    logic [1:0]  port_nxt;
    logic [1:0]  mode_r;
    logic [1:0]  mode_nxt;
    logic        rasHold_r;
    logic        rasHold_nxt;
    logic        tsN_r;
    logic        tsN_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [3:0]  dataOe_r;
    logic [3:0]  dataOe_nxt;
    logic        done_r;
    logic        done_nxt;
    logic [1:0]  preCnt_r;
    logic [1:0]  preCnt_nxt;
    logic        reqBank;
    logic [1:0]  reqMode;
    logic [1:0]  reqPort;
    logic        pageHit;
    logic        pageMiss;
    logic [27:0] nextAddr;

    assign reqBank  = reqAddr[dram_seq_pkg::BANK_BIT];
    assign reqMode  = reqBank ? bankCfg_r[dram_seq_pkg::B1_MODE_LSB +: 2]
                              : bankCfg_r[dram_seq_pkg::B0_MODE_LSB +: 2];
    assign reqPort  = reqBank ? bankCfg_r[dram_seq_pkg::B1_PORT_LSB +: 2]
                              : bankCfg_r[dram_seq_pkg::B0_PORT_LSB +: 2];
    assign pageHit  = pageOpen_r && (openRow_r == reqAddr[27:9]);
    assign pageMiss = pageOpen_r && !pageHit;
    assign reqReady = (state_r == dram_seq_pkg::ST_IDLE) && !pageMiss;
    assign nextAddr = curAddr_r + 28'(portBytes(port_r));

    always_comb begin
        state_nxt     = state_r;
        beatsLeft_nxt = beatsLeft_r;
        curAddr_nxt   = curAddr_r;
        addrOut_nxt   = addrOut_r;
        wdata_nxt     = wdata_r;
        rdata_nxt     = rdata_r;
        write_nxt     = write_r;
        dirN_nxt      = dirN_r;
        size_nxt      = size_r;
        port_nxt      = port_r;
        mode_nxt      = mode_r;
        pageOpen_nxt  = pageOpen_r;
        openRow_nxt   = openRow_r;
        rasHold_nxt   = rasHold_r;
        dataOe_nxt    = dataOe_r;
        preCnt_nxt    = preCnt_r;
        tsN_nxt       = 1'b1;
        ack_nxt       = 1'b0;
        done_nxt      = 1'b0;
        case (state_r)
            dram_seq_pkg::ST_IDLE: begin
                if (reqValid && pageMiss) begin
                    // open page missed: close now, row may start next cycle
                    rasHold_nxt  = 1'b0; // R18
                    pageOpen_nxt = 1'b0; // R18
                end else if (reqValid) begin
                    beatsLeft_nxt = extraBeats(reqSize, reqPort); // R21
                    // read beats shift in, so start the operand from zero
                    rdata_nxt     = 32'h0000_0000;
                    curAddr_nxt   = reqAddr;
                    write_nxt     = reqWrite;
                    dirN_nxt      = !reqWrite; // R23
                    size_nxt      = reqSize; // R10 R19
                    port_nxt      = reqPort;
                    mode_nxt      = reqMode;
                    if (reqSize == dram_seq_pkg::SIZE_BYTE) begin
                        wdata_nxt = {reqWdata[7:0], 24'h00_0000};
                    end else if (reqSize == dram_seq_pkg::SIZE_WORD) begin
                        wdata_nxt = {reqWdata[15:0], 16'h0000};
                    end else begin
                        wdata_nxt = reqWdata;
                    end
                    if (pageHit) begin
                        addrOut_nxt = colOf(reqAddr);
                        dataOe_nxt  = reqWrite ? dataLanes(reqPort) : 4'h0;
                        state_nxt   = dram_seq_pkg::ST_COL;
                    end else begin
                        addrOut_nxt = reqAddr[27:9]; // R1
                        tsN_nxt     = 1'b0; // R10 R19
                        rasHold_nxt = 1'b1; // R1
                        state_nxt   = dram_seq_pkg::ST_ROW;
                    end
                end
            end
            dram_seq_pkg::ST_ROW: begin
                addrOut_nxt = colOf(curAddr_r); // R2
                dataOe_nxt  = write_r ? dataLanes(port_r) : 4'h0; // R2
                state_nxt   = dram_seq_pkg::ST_COL;
            end
            dram_seq_pkg::ST_COL: begin
                ack_nxt   = 1'b1; // R4
                state_nxt = dram_seq_pkg::ST_ACK;
            end
            dram_seq_pkg::ST_ACK: begin
                if (!write_r) begin
                    // R11 R15 R16
                    if (port_r == dram_seq_pkg::PORT_8) begin
                        rdata_nxt = {rdata_r[23:0], dataIn[31:24]};
                    end else if (port_r == dram_seq_pkg::PORT_16) begin
                        rdata_nxt = {rdata_r[15:0], dataIn[31:16]};
                    end else begin
                        rdata_nxt = dataIn;
                    end
                end
                if (beatsLeft_r != 2'h0) begin
                    // next beat: two clocks, RAS kept
                    beatsLeft_nxt = beatsLeft_r - 2'h1; // R22
                    curAddr_nxt   = nextAddr; // R5
                    addrOut_nxt   = colOf(nextAddr); // R5
                    if (port_r == dram_seq_pkg::PORT_8) begin
                        wdata_nxt = {wdata_r[23:0], 8'h00}; // R5
                    end else begin
                        wdata_nxt = {wdata_r[15:0], 16'h0000}; // R5
                    end
                    state_nxt = dram_seq_pkg::ST_COL;
                end else begin
                    done_nxt   = 1'b1;
                    dataOe_nxt = 4'h0; // R7
                    dirN_nxt   = 1'b1;
                    if (mode_r == dram_seq_pkg::MODE_FAST) begin
                        pageOpen_nxt = 1'b1; // R17
                        openRow_nxt  = curAddr_r[27:9]; // R17
                        state_nxt    = dram_seq_pkg::ST_IDLE;
                    end else begin
                        rasHold_nxt = 1'b0; // R6 R9 R11
                        preCnt_nxt  = dram_seq_pkg::PRE_LOAD; // R8
                        state_nxt   = dram_seq_pkg::ST_PRE;
                    end
                end
            end
            dram_seq_pkg::ST_PRE: begin
                if (preCnt_r == 2'h0) begin
                    state_nxt = dram_seq_pkg::ST_IDLE; // R8
                end else begin
                    preCnt_nxt = preCnt_r - 2'h1;
                end
            end
            default: begin
                state_nxt = dram_seq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r     <= dram_seq_pkg::ST_IDLE;
            beatsLeft_r <= 2'h0;
            curAddr_r   <= 28'h000_0000;
            addrOut_r   <= 19'h0_0000;
            wdata_r     <= 32'h0000_0000;
            rdata_r     <= 32'h0000_0000;
            write_r     <= 1'b0;
            dirN_r      <= 1'b1;
            size_r      <= 2'h0;
            port_r      <= 2'h0;
            mode_r      <= 2'h0;
            pageOpen_r  <= 1'b0;
            openRow_r   <= 19'h0_0000;
            rasHold_r   <= 1'b0;
            tsN_r       <= 1'b1;
            ack_r       <= 1'b0;
            dataOe_r    <= 4'h0;
            done_r      <= 1'b0;
            preCnt_r    <= 2'h0;
        end else begin
            state_r     <= state_nxt;
            beatsLeft_r <= beatsLeft_nxt;
            curAddr_r   <= curAddr_nxt;
            addrOut_r   <= addrOut_nxt;
            wdata_r     <= wdata_nxt;
            rdata_r     <= rdata_nxt;
            write_r     <= write_nxt;
            dirN_r      <= dirN_nxt;
            size_r      <= size_nxt;
            port_r      <= port_nxt;
            mode_r      <= mode_nxt;
            pageOpen_r  <= pageOpen_nxt;
            openRow_r   <= openRow_nxt;
            rasHold_r   <= rasHold_nxt;
            tsN_r       <= tsN_nxt;
            ack_r       <= ack_nxt;
            dataOe_r    <= dataOe_nxt;
            done_r      <= done_nxt;
            preCnt_r    <= preCnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // strobe timing, falling edge
    // ------------------------------------------------------------
    logic rasNeg_r;
    logic rasNeg_nxt;
    logic casCol_r;
    logic casCol_nxt;
    logic casEdo_r;
    logic casEdo_nxt;
    logic casOn;

    always_comb begin
        rasNeg_nxt = rasHold_r; // R1
        casCol_nxt = (state_r == dram_seq_pkg::ST_COL); // R3
        casEdo_nxt = edoEnable && ack_r; // R13 R15
    end

    always_ff @(negedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rasNeg_r <= 1'b0;
            casCol_r <= 1'b0;
            casEdo_r <= 1'b0;
        end else begin
            rasNeg_r <= rasNeg_nxt;
            casCol_r <= casCol_nxt;
            casEdo_r <= casEdo_nxt;
        end
    end

    // rises at the falling edge inside the column cycle; without edo it
    // falls at the next rising edge after acknowledge, with edo half a
    // clock sooner, so the gap to the next beat is a full clock
    assign casOn = casCol_r || (ack_r && !casEdo_r); // R13 R14 R15

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rasN                = !(rasHold_r && rasNeg_r); // R1 R6 R18
    assign casN                = ~(casLanes(port_r) & {4{casOn}}); // R3 R16
    assign dramAddr            = addrOut_r;
    assign transferStartN      = tsN_r;
    assign dramWriteIndicatorN = dirN_r;
    assign transferSizeCode    = size_r;
    assign dataOut             = wdata_r;
    assign dataOe              = dataOe_r;
    assign beatAck             = ack_r;
    assign reqDone             = done_r;
    assign reqRdata            = rdata_r;

endmodule

`default_nettype wire

// file: dram_seq_pkg.sv
// constants and types for the dram strobe sequencer
package dram_seq_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TIMING_OFS  = 8'h00;
    localparam logic [7:0] BANKCFG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS  = 8'h08;

    localparam logic [31:0] TIMING_RST  = 32'h0000_0000;
    localparam logic [31:0] BANKCFG_RST = 32'h0000_0000;

    localparam int EDO_BIT     = 0;
    localparam int B0_MODE_LSB = 0;
    localparam int B0_PORT_LSB = 2;
    localparam int B1_MODE_LSB = 4;
    localparam int B1_PORT_LSB = 6;
    localparam int ST_OPEN_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_BANK_BIT = 2;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_BURST  = 2'h1;
    localparam logic [1:0] MODE_FAST   = 2'h2;

    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8  = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;

    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;

    // ------------------------------------------------------------
    // address and timing
    // ------------------------------------------------------------
    localparam int BANK_BIT = 27;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAS_GAP_CLK = 2;
    localparam logic [1:0] PRE_LOAD = 2'(RAS_GAP_CLK - 2);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW,
        ST_COL,
        ST_ACK,
        ST_PRE
    } state_t;

endpackage

// file: dram_seq_asserts.sv
// concurrent checks on the dram strobe sequencer ports
`timescale 1ns/1ps
`default_nettype none

module dram_seq_asserts (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       beatAck,
    input wire logic       reqDone,
    input wire logic       rasN,
    input wire logic [3:0] casN,
    input wire logic       transferStartN,
    input wire logic       dramWriteIndicatorN,
    input wire logic [3:0] dataOe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // transfer steps
    // ----------------------------------------
    sequence rowStart;
        $fell(transferStartN);
    endsequence
    sequence beatMid;
        beatAck ##1 !reqDone;
    endsequence

    row_strobe_a: assert property (rowStart |-> !rasN && $past(rasN))
        else $error("row strobe not asserted after row address");
    start_pulse_a: assert property (rowStart |=> transferStartN)
        else $error("transfer start longer than one cycle");
    write_lanes_a: assert property (rowStart and !dramWriteIndicatorN |=> dataOe[3])
        else $error("write data not driven on top lanes");
    first_ack_a: assert property (rowStart |-> ##2 beatAck)
        else $error("first beat acknowledge not two cycles after start");
    next_beat_a: assert property (beatMid |-> ##1 beatAck)
        else $error("following beat not two cycles long");
    ack_pulse_a: assert property (beatAck |=> !beatAck)
        else $error("acknowledge longer than one cycle");
    done_ack_a: assert property (reqDone |-> $past(beatAck) && !beatAck)
        else $error("completion without acknowledge one cycle before");
    close_strobes_a: assert property (reqDone |-> casN == 4'hF && dataOe == 4'h0)
        else $error("column strobes or data bus still active at completion");
    ras_gap_a: assert property ($rose(rasN) |-> transferStartN && casN == 4'hF)
        else $error("row strobe precharge cut short");
    pre_gap_a: assert property ($rose(rasN) && reqDone |=> transferStartN)
        else $error("next row started inside precharge gap");
    write_dir_a: assert property (dataOe != 4'h0 |-> !dramWriteIndicatorN)
        else $error("data driven without write indicator");
    cas_in_row_a: assert property (casN != 4'hF |-> !rasN)
        else $error("column strobe outside open row");
endmodule

bind dram_burst_page_edo_timing dram_seq_asserts u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .beatAck(beatAck), .reqDone(reqDone),
    .rasN(rasN), .casN(casN), .transferStartN(transferStartN),
    .dramWriteIndicatorN(dramWriteIndicatorN), .dataOe(dataOe));

`default_nettype wire

// file: dram_page_model.sv
// behavioural page-mode and edo dram answering reads
`timescale 1ns/1ps
`default_nettype none

module dram_page_model (
    input  wire logic        rasN,
    input  wire logic [3:0]  casN,
    input  wire logic        dramWriteIndicatorN,
    input  wire logic [18:0] dramAddr,
    input  wire logic        edoMode,
    output logic      [31:0] dataIn
);
    logic [31:0] word;
    logic        driving;

    initial begin
        word = 32'h0;
        driving = 1'b0;
    end
    // column picks a lane pattern; narrow ports read the top lanes
    always @(negedge casN[0]) begin
        word = {dramAddr[7:0] ^ 8'h5A, dramAddr[7:0] ^ 8'hA5,
                dramAddr[7:0] ^ 8'h3C, dramAddr[7:0] ^ 8'hC3};
        driving = dramWriteIndicatorN;
    end
    // page mode parts release at cas rise, edo parts hold until ras rise
    always @(posedge casN[0]) if (!edoMode) driving = 1'b0;
    always @(posedge rasN) driving = 1'b0;
    // released lines show the inverse, never the stale value
    assign dataIn = driving ? word : ~word;
endmodule

`default_nettype wire

// file: dram_burst_page_edo_timing_tb_top.sv
// self-checking bench for the dram strobe sequencer
`timescale 1ns/1ps
`default_nettype none

module dram_burst_page_edo_timing_tb_top;
    typedef struct {
        logic [7:0] cfg; logic edo; logic wr; logic [27:0] addr; logic [1:0] size;
        logic newRow; int lat; logic [3:0] lanes; logic [31:0] rdata;
    } case_t;

    logic        clk_sys = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic        reqValid = 1'b0, reqWrite = 1'b0, edoSel = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, reqWdata = 32'h0;
    logic [27:0] reqAddr = 28'h0;
    logic [1:0]  reqSize = 2'h0;
    logic        reqReady, beatAck, reqDone, rasN, transferStartN, dramWriteIndicatorN;
    logic [31:0] regRdata, reqRdata, dataIn, dataOut;
    logic [18:0] dramAddr;
    logic [3:0]  casN, dataOe;
    logic [1:0]  transferSizeCode;
    int          fails = 0, samplesChecked = 0;
    time         doneT = 0;

    case_t rows [8] = '{
        '{8'h00, 1'b0, 1'b0, 28'h0000010, dram_seq_pkg::SIZE_LONG, 1'b1, 4, 4'h0, 32'h4AB52CD3},
        '{8'h09, 1'b0, 1'b1, 28'h0000010, dram_seq_pkg::SIZE_LONG, 1'b1, 6, 4'hC, 32'h0},
        '{8'h09, 1'b0, 1'b0, 28'h0000010, dram_seq_pkg::SIZE_WORD, 1'b1, 4, 4'hC, 32'h00004AB5},
        '{8'h05, 1'b0, 1'b0, 28'h0000010, dram_seq_pkg::SIZE_WORD, 1'b1, 6, 4'hE, 32'h00004A4B},
        '{8'h90, 1'b1, 1'b0, 28'h8000010, dram_seq_pkg::SIZE_LONG, 1'b1, 6, 4'hC, 32'h4AB548B7},
        '{8'h06, 1'b0, 1'b0, 28'h0000010, dram_seq_pkg::SIZE_BYTE, 1'b1, 4, 4'hE, 32'h0000004A},
        '{8'h06, 1'b0, 1'b0, 28'h0000011, dram_seq_pkg::SIZE_BYTE, 1'b0, 3, 4'hE, 32'h0000004B},
        '{8'h06, 1'b0, 1'b0, 28'h0000210, dram_seq_pkg::SIZE_BYTE, 1'b1, 4, 4'hE, 32'h0000004A}};

    always #5 clk_sys = ~clk_sys;

    dram_burst_page_edo_timing u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqSize(reqSize), .reqWdata(reqWdata),
        .reqReady(reqReady), .beatAck(beatAck), .reqDone(reqDone), .reqRdata(reqRdata),
        .dramAddr(dramAddr), .rasN(rasN), .casN(casN), .transferStartN(transferStartN),
        .dramWriteIndicatorN(dramWriteIndicatorN), .transferSizeCode(transferSizeCode),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

    dram_page_model u_mem (
        .rasN(rasN), .casN(casN), .dramWriteIndicatorN(dramWriteIndicatorN),
        .dramAddr(dramAddr), .edoMode(edoSel), .dataIn(dataIn));

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk("regRdata", exp, regRdata);
        @(posedge clk_sys);
        #1 chk("regRdata idle", 32'h0, regRdata);
    endtask

    task automatic run_case(input case_t r);
        int  n;
        logic [1:0] mode;
        mode = r.addr[27] ? r.cfg[5:4] : r.cfg[1:0];
        edoSel = r.edo;
        reg_wr(dram_seq_pkg::TIMING_OFS, {31'h0, r.edo});
        reg_wr(dram_seq_pkg::BANKCFG_OFS, {24'h0, r.cfg});
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= r.wr;
        reqAddr <= r.addr;
        reqSize <= r.size;
        reqWdata <= 32'h1234ABCD;
        n = 0;
        do begin
            @(negedge clk_sys);
            #2 n++;
        end while (reqReady !== 1'b1 && n < 50);
        @(posedge clk_sys);
        reqValid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            #2 n++;
            if (n == 1) chk("start", 32'(!r.newRow), 32'(transferStartN));
            if (n == 1 && r.newRow) begin
                chk("size", 32'(r.size), 32'(transferSizeCode));
                chk("dir", 32'(!r.wr), 32'(dramWriteIndicatorN));
                chk("row", 32'(r.addr[27:9]), 32'(dramAddr));
                chk("gap", 32'h1, 32'($time - doneT >= 20));
            end
            if (n == 2) chk("oe", 32'(r.wr ? 4'hC : 4'h0), 32'(dataOe));
            if (n == 2 && r.newRow) chk("col", 32'(r.addr[8:0]), 32'(dramAddr));
            if (r.wr && (n == 2 || n == 4))
                chk("wdata", (n == 2) ? 32'h1234 : 32'hABCD, 32'(dataOut[31:16]));
            if (beatAck === 1'b1) chk("cas", 32'(r.edo ? 4'hF : r.lanes), 32'(casN));
        end while (reqDone !== 1'b1 && n < 50);
        chk("latency", 32'(r.lat), 32'(n));
        if (!r.wr) chk("rdata", r.rdata, reqRdata);
        chk("ras end", 32'(mode != dram_seq_pkg::MODE_FAST), 32'(rasN));
        chk("oe end", 32'h0, 32'(dataOe));
        doneT = $time;
        if (n >= 50) begin
            fails++;
            stop_test();
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 chk("reset strobes", 32'h00000FC1, {20'h0, rasN, casN, transferStartN, dataOe, 2'h1});
        reg_rd(dram_seq_pkg::TIMING_OFS, dram_seq_pkg::TIMING_RST);
        reg_rd(dram_seq_pkg::BANKCFG_OFS, dram_seq_pkg::BANKCFG_RST);
        foreach (rows[i]) run_case(rows[i]);
        // ----------------------------------------
        // register map edges and reset mid-page
        // ----------------------------------------
        reg_rd(dram_seq_pkg::BANKCFG_OFS, 32'h00000006);
        reg_rd(8'h0C, 32'h0);
        reg_rd(dram_seq_pkg::STATUS_OFS, 32'h1);
        @(posedge clk_sys);
        resetn <= 1'b0;
        #2 chk("ras in reset", 32'h1F, {27'h0, rasN, casN});
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        reg_rd(dram_seq_pkg::STATUS_OFS, 32'h0);
        stop_test();
    end
endmodule

`default_nettype wire
